/* File: byte_queue.sv */
`timescale 1ns/1ps
module byte_queue #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 64
) (
    // clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       reset_n,
    // fill side
    input  wire logic                       push_valid,
    output logic                            push_ready,
    input  wire logic [WIDTH-1:0]           push_data,
    // drain side
    output logic                            pop_valid,
    input  wire logic                       pop_ready,
    output logic      [WIDTH-1:0]           pop_data,
    // control and state
    input  wire logic                       flush,
    output logic      [$clog2(DEPTH):0]     level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_ptr;
    logic [AW:0]      rd_ptr;
    logic             settled;
    wire              empty     = (wr_ptr == rd_ptr);
    wire              full      = (level == (AW+1)'(DEPTH));
    wire              push_fire = push_valid & push_ready;
    wire              pop_fire  = pop_valid & pop_ready;

    assign level      = wr_ptr - rd_ptr;
    assign push_ready = ~full;
    // read data is registered, so the head is only offered once it has settled
    assign pop_valid  = ~empty & settled;

    always_ff @(posedge sys_clk) begin
        if (push_fire) begin
            mem[wr_ptr[AW-1:0]] <= push_data;
        end
        pop_data <= mem[rd_ptr[AW-1:0]];
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n || flush) begin
            wr_ptr  <= '0;
            rd_ptr  <= '0;
            settled <= 1'b0;
        end else begin
            wr_ptr  <= wr_ptr + (AW+1)'(push_fire);
            rd_ptr  <= rd_ptr + (AW+1)'(pop_fire);
            settled <= ~(push_fire | pop_fire);
        end
    end
endmodule : byte_queue

/* File: checksum_unit.sv */
`timescale 1ns/1ps
`include "nfc_host_regs.svh"
module checksum_unit (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // control
    input  wire logic        restart,
    input  wire logic [1:0]  start_select,
    input  wire logic        msb_first,
    // data
    input  wire logic        feed,
    input  wire logic [7:0]  feed_data,
    output logic      [15:0] result
);
    function automatic logic [15:0] step_byte(input logic [15:0] c, input logic [7:0] d,
                                              input logic msb);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            if (msb) begin
                r = (r[15] ^ d[7-i]) ? ({r[14:0], 1'b0} ^ `CHECKSUM_POLY_MSB)
                                     : {r[14:0], 1'b0};
            end else begin
                r = (r[0] ^ d[i]) ? ({1'b0, r[15:1]} ^ `CHECKSUM_POLY_LSB)
                                  : {1'b0, r[15:1]};
            end
        end
        return r;
    endfunction : step_byte

    wire [15:0] preset = (start_select == 2'h0) ? `CHECKSUM_PRESET_0 :
                         (start_select == 2'h1) ? `CHECKSUM_PRESET_1 :
                         (start_select == 2'h2) ? `CHECKSUM_PRESET_2 : `CHECKSUM_PRESET_3;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            result <= `CHECKSUM_PRESET_0;
        end else if (restart) begin
            result <= preset;
        end else if (feed) begin
            result <= step_byte(result, feed_data, msb_first);
        end
    end
endmodule : checksum_unit

/* File: nfc_host_pkg.sv */
package nfc_host_pkg;
    typedef enum logic [1:0] {
        SER_ADDR = 2'b00,
        SER_DATA = 2'b01,
        SER_SEND = 2'b10
    } serial_state_type;
    typedef enum logic [2:0] {
        TW_IDLE    = 3'b000,
        TW_DEVADDR = 3'b001,
        TW_REGADDR = 3'b010,
        TW_WDATA   = 3'b011,
        TW_RDATA   = 3'b100
    } two_wire_state_type;
endpackage : nfc_host_pkg

/* File: nfc_host_port.sv */
`timescale 1ns/1ps
`include "nfc_host_regs.svh"
module nfc_host_port #(
    parameter int QUEUE_DEPTH = 64
) (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset_n,
    // interface strap
    input  wire logic       interface_select_strap,
    // serial host link
    input  wire logic       host_serial_in,
    output logic            host_serial_out,
    // two-wire host link
    input  wire logic       two_wire_clock_pin,
    input  wire logic       two_wire_data_in,
    output logic            two_wire_data_out,
    output logic            two_wire_data_oe,
    // internal state machine side of the queue
    input  wire logic       core_push_valid,
    output logic            core_push_ready,
    input  wire logic [7:0] core_push_data,
    output logic            core_pop_valid,
    input  wire logic       core_pop_ready,
    output logic      [7:0] core_pop_data,
    // status
    output logic            two_wire_selected
);
    // ---------------- strap capture
    logic strap_taken;
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            strap_taken       <= 1'b0;
            two_wire_selected <= 1'b0;
        end else if (!strap_taken) begin
            strap_taken       <= 1'b1;
            two_wire_selected <= interface_select_strap;
        end
    end

    // ---------------- shared register access
    logic       ser_wr, ser_rd, tw_wr, tw_rd;
    logic [5:0] ser_addr, tw_addr;
    logic [7:0] ser_wdata, tw_wdata;
    wire        acc_wr    = two_wire_selected ? tw_wr : ser_wr;
    wire        acc_rd    = two_wire_selected ? tw_rd : ser_rd;
    wire  [5:0] acc_addr  = two_wire_selected ? tw_addr : ser_addr;
    wire  [7:0] acc_wdata = two_wire_selected ? tw_wdata : ser_wdata;

    logic [7:0]  serial_rate_setting;
    logic [7:0]  checksum_ctrl;
    logic        queue_overrun_flag;
    logic [15:0] checksum_value;
    logic [$clog2(QUEUE_DEPTH):0] queue_level;
    logic [7:0]  queue_head;
    logic        queue_push_ready;
    logic        queue_pop_valid;

    wire wr_data_reg  = acc_wr & (acc_addr == `ADDR_QUEUE_DATA);
    wire rd_data_reg  = acc_rd & (acc_addr == `ADDR_QUEUE_DATA);
    wire queue_flush  = acc_wr & (acc_addr == `ADDR_QUEUE_LEVEL)
                        & acc_wdata[`LEVEL_FLUSH_BIT];
    wire ck_restart   = acc_wr & (acc_addr == `ADDR_CHECKSUM_CTRL)
                        & acc_wdata[`CTRL_RESTART_BIT];
    wire ck_feed      = acc_wr & (acc_addr == `ADDR_CHECKSUM_FEED);
    // host accesses win over the internal side in the same cycle
    wire q_push_valid = wr_data_reg | core_push_valid;
    wire [7:0] q_push_data = wr_data_reg ? acc_wdata : core_push_data;
    wire q_pop_ready  = rd_data_reg | core_pop_ready;
    assign core_push_ready = queue_push_ready & ~wr_data_reg;
    assign core_pop_valid  = queue_pop_valid & ~rd_data_reg;

    wire [7:0] rd_mux =
        (acc_addr == `ADDR_QUEUE_DATA)     ? queue_head :
        (acc_addr == `ADDR_QUEUE_LEVEL)    ? {1'b0, 7'(queue_level)} :
        (acc_addr == `ADDR_OVERRUN_STATUS) ? {7'h00, queue_overrun_flag} :
        (acc_addr == `ADDR_CHECKSUM_CTRL)  ? {1'b0, checksum_ctrl[6:0]} :
        (acc_addr == `ADDR_SERIAL_RATE)    ? serial_rate_setting :
        (acc_addr == `ADDR_CHECKSUM_HIGH)  ? checksum_value[15:8] :
        (acc_addr == `ADDR_CHECKSUM_LOW)   ? checksum_value[7:0] : 8'h00;

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            serial_rate_setting <= `SERIAL_RATE_RESET;
            checksum_ctrl       <= `CHECKSUM_CTRL_RESET;
            queue_overrun_flag  <= 1'b0;
        end else begin
            if (acc_wr && acc_addr == `ADDR_SERIAL_RATE) begin
                serial_rate_setting <= acc_wdata;
            end
            if (acc_wr && acc_addr == `ADDR_CHECKSUM_CTRL) begin
                checksum_ctrl <= acc_wdata;
            end
            if (queue_flush) begin
                queue_overrun_flag <= 1'b0;
            end else if (wr_data_reg && !queue_push_ready) begin
                queue_overrun_flag <= 1'b1;
            end
        end
    end

    byte_queue #(
        .WIDTH (8),
        .DEPTH (QUEUE_DEPTH)
    ) u_queue (
        .sys_clk    (sys_clk),
        .reset_n    (reset_n),
        .push_valid (q_push_valid),
        .push_ready (queue_push_ready),
        .push_data  (q_push_data),
        .pop_valid  (queue_pop_valid),
        .pop_ready  (q_pop_ready),
        .pop_data   (queue_head),
        .flush      (queue_flush),
        .level      (queue_level)
    );
    assign core_pop_data = queue_head;

    checksum_unit u_checksum (
        .sys_clk      (sys_clk),
        .reset_n      (reset_n),
        .restart      (ck_restart),
        .start_select (checksum_ctrl[1:0]),
        .msb_first    (checksum_ctrl[`CTRL_ORDER_BIT]),
        .feed         (ck_feed),
        .feed_data    (acc_wdata),
        .result       (checksum_value)
    );

    // ---------------- serial bit timing
    function automatic logic [12:0] bit_period(input logic [7:0] rate);
        logic [12:0] base;
        base = {8'h00, rate[4:0]} + `RATE_MANT_OFFSET;
        if (rate[7:5] == 3'h0) begin
            return {8'h00, rate[4:0]} + 13'h0001;
        end
        return base << (rate[7:5] - 3'h1);
    endfunction : bit_period

    // sys_clk is the crystal reference; the period is counted in its cycles
    wire [12:0] period = bit_period(serial_rate_setting);

    // receiver
    logic        rx_q, rx_busy, rx_done;
    logic [3:0]  rx_bit;
    logic [12:0] rx_cnt;
    logic [7:0]  rx_byte;
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rx_q    <= 1'b1;
            rx_busy <= 1'b0;
            rx_done <= 1'b0;
            rx_bit  <= 4'h0;
            rx_cnt  <= 13'h0000;
            rx_byte <= 8'h00;
        end else begin
            rx_q    <= host_serial_in;
            rx_done <= 1'b0;
            if (!rx_busy) begin
                if (rx_q && !host_serial_in && !two_wire_selected) begin
                    rx_busy <= 1'b1;
                    rx_bit  <= 4'h0;
                    rx_cnt  <= {1'b0, period[12:1]};
                end
            end else if (rx_cnt != 13'h0000) begin
                rx_cnt <= rx_cnt - 13'h0001;
            end else begin
                rx_cnt <= period - 13'h0001;
                rx_bit <= rx_bit + 4'h1;
                if (rx_bit == 4'h0 && host_serial_in) begin
                    rx_busy <= 1'b0; // false start
                end else if (rx_bit == 4'h9) begin
                    rx_busy <= 1'b0;
                    rx_done <= host_serial_in;
                end else if (rx_bit != 4'h0) begin
                    rx_byte <= {host_serial_in, rx_byte[7:1]};
                end
            end
        end
    end

    // transmitter
    logic        tx_load, tx_busy;
    logic [9:0]  tx_sr;
    logic [3:0]  tx_bit;
    logic [12:0] tx_cnt;
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            tx_busy         <= 1'b0;
            tx_sr           <= 10'h3FF;
            tx_bit          <= 4'h0;
            tx_cnt          <= 13'h0000;
            host_serial_out <= 1'b1;
        end else if (tx_load) begin
            tx_busy <= 1'b1;
            tx_sr   <= {1'b1, rd_mux, 1'b0};
            tx_bit  <= 4'h0;
            tx_cnt  <= period - 13'h0001;
        end else if (tx_busy) begin
            host_serial_out <= tx_sr[0];
            if (tx_cnt != 13'h0000) begin
                tx_cnt <= tx_cnt - 13'h0001;
            end else begin
                tx_cnt <= period - 13'h0001;
                tx_sr  <= {1'b1, tx_sr[9:1]};
                tx_bit <= tx_bit + 4'h1;
                tx_busy <= (tx_bit != 4'h9);
            end
        end else begin
            host_serial_out <= 1'b1;
        end
    end

    // serial transaction sequencing
    nfc_host_pkg::serial_state_type ser_state;
    wire ser_is_read = rx_byte[`ADDR_BYTE_READ_BIT];
    assign ser_rd    = (ser_state == nfc_host_pkg::SER_SEND);
    assign tx_load   = ser_rd;
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ser_state <= nfc_host_pkg::SER_ADDR;
            ser_wr    <= 1'b0;
            ser_addr  <= 6'h00;
            ser_wdata <= 8'h00;
        end else begin
            ser_wr <= 1'b0;
            case (ser_state)
                nfc_host_pkg::SER_ADDR: begin
                    if (rx_done) begin
                        ser_addr  <= rx_byte[5:0];
                        ser_state <= ser_is_read ? nfc_host_pkg::SER_SEND
                                                 : nfc_host_pkg::SER_DATA;
                    end
                end
                nfc_host_pkg::SER_DATA: begin
                    if (rx_done) begin
                        ser_wr    <= 1'b1;
                        ser_wdata <= rx_byte;
                        ser_state <= nfc_host_pkg::SER_ADDR;
                    end
                end
                nfc_host_pkg::SER_SEND: begin
                    ser_state <= nfc_host_pkg::SER_ADDR;
                end
                default: begin
                    ser_state <= nfc_host_pkg::SER_ADDR;
                end
            endcase
        end
    end

    // ---------------- two-wire slave
    nfc_host_pkg::two_wire_state_type tw_state;
    logic       scl_q, sda_q, ack_on, mnack;
    logic [3:0] tw_cnt;
    logic [7:0] tw_sr, tw_tx;
    wire scl_rise = two_wire_clock_pin & ~scl_q;
    wire scl_fall = ~two_wire_clock_pin & scl_q;
    wire tw_start = two_wire_clock_pin & scl_q & sda_q & ~two_wire_data_in;
    wire tw_stop  = two_wire_clock_pin & scl_q & ~sda_q & two_wire_data_in;
    wire tw_recv  = (tw_state != nfc_host_pkg::TW_RDATA) & (tw_state != nfc_host_pkg::TW_IDLE);
    wire addr_hit = (tw_sr[7:1] == `TWO_WIRE_DEV_ADDR);
    wire byte_end = scl_fall & ~ack_on & tw_recv & (tw_cnt == 4'h8);
    wire rd_next  = scl_fall & (tw_state == nfc_host_pkg::TW_RDATA) & (tw_cnt == 4'h9) & ~mnack;

    assign tw_rd = (byte_end & (tw_state == nfc_host_pkg::TW_DEVADDR) & addr_hit & tw_sr[0])
                   | rd_next;
    assign tw_wr = byte_end & (tw_state == nfc_host_pkg::TW_WDATA);
    assign tw_wdata = tw_sr;
    // open drain: only ever pulls low
    assign two_wire_data_out = 1'b0;
    assign two_wire_data_oe  = ack_on | ((tw_state == nfc_host_pkg::TW_RDATA)
                                         & (tw_cnt < 4'h8) & ~tw_tx[7]);

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            scl_q    <= 1'b1;
            sda_q    <= 1'b1;
            tw_state <= nfc_host_pkg::TW_IDLE;
            ack_on   <= 1'b0;
            mnack    <= 1'b0;
            tw_cnt   <= 4'h0;
            tw_sr    <= 8'h00;
            tw_tx    <= 8'hFF;
            tw_addr  <= 6'h00;
        end else begin
            scl_q <= two_wire_clock_pin;
            sda_q <= two_wire_data_in;
            if (!two_wire_selected || tw_stop) begin
                tw_state <= nfc_host_pkg::TW_IDLE;
                ack_on   <= 1'b0;
            end else if (tw_start) begin
                tw_state <= nfc_host_pkg::TW_DEVADDR;
                tw_cnt   <= 4'h0;
                ack_on   <= 1'b0;
            end else if (scl_rise) begin
                if (tw_recv && !ack_on) begin
                    tw_sr  <= {tw_sr[6:0], two_wire_data_in};
                    tw_cnt <= tw_cnt + 4'h1;
                end else if (tw_state == nfc_host_pkg::TW_RDATA) begin
                    if (tw_cnt == 4'h8) begin
                        mnack <= two_wire_data_in;
                    end
                    tw_cnt <= tw_cnt + 4'h1;
                end
            end else if (scl_fall) begin
                if (ack_on) begin
                    ack_on <= 1'b0;
                    tw_cnt <= 4'h0;
                end else if (byte_end) begin
                    tw_cnt <= 4'h0;
                    case (tw_state)
                        nfc_host_pkg::TW_DEVADDR: begin
                            ack_on <= addr_hit;
                            if (!addr_hit) begin
                                tw_state <= nfc_host_pkg::TW_IDLE;
                            end else if (tw_sr[0]) begin
                                tw_state <= nfc_host_pkg::TW_RDATA;
                                tw_tx    <= rd_mux;
                            end else begin
                                tw_state <= nfc_host_pkg::TW_REGADDR;
                            end
                        end
                        nfc_host_pkg::TW_REGADDR: begin
                            ack_on   <= 1'b1;
                            tw_addr  <= tw_sr[5:0];
                            tw_state <= nfc_host_pkg::TW_WDATA;
                        end
                        nfc_host_pkg::TW_WDATA: begin
                            ack_on <= 1'b1;
                        end
                        default: begin
                            tw_state <= nfc_host_pkg::TW_IDLE;
                        end
                    endcase
                end else if (tw_state == nfc_host_pkg::TW_RDATA) begin
                    if (tw_cnt < 4'h8) begin
                        tw_tx <= {tw_tx[6:0], 1'b1};
                    end else if (tw_cnt == 4'h9) begin
                        // master ack fetches the next byte, nack ends the read
                        tw_cnt   <= 4'h0;
                        tw_tx    <= rd_mux;
                        tw_state <= mnack ? nfc_host_pkg::TW_IDLE
                                          : nfc_host_pkg::TW_RDATA;
                    end
                end
            end
        end
    end
endmodule : nfc_host_port

/* File: nfc_host_port_assertions.sv */
`timescale 1ns/1ps
module nfc_host_port_assertions #(
    parameter int QUEUE_DEPTH = 64
) (
    // clock and reset
    input wire logic       sys_clk,
    input wire logic       reset_n,
    // pins
    input wire logic       interface_select_strap,
    input wire logic       host_serial_in,
    input wire logic       host_serial_out,
    input wire logic       two_wire_clock_pin,
    input wire logic       two_wire_data_in,
    input wire logic       two_wire_data_out,
    input wire logic       two_wire_data_oe,
    input wire logic       two_wire_selected,
    // internal queue side
    input wire logic       core_push_valid,
    input wire logic       core_push_ready,
    input wire logic [7:0] core_push_data,
    input wire logic       core_pop_valid,
    input wire logic       core_pop_ready,
    input wire logic [7:0] core_pop_data
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    property p_strap_take;
        reset_n && !$past(reset_n) |=> two_wire_selected == $past(interface_select_strap);
    endproperty
    // two deep so the capture edge itself is not mistaken for a change
    property p_strap_hold; $past(reset_n) && $past(reset_n, 2) |-> $stable(two_wire_selected);
    endproperty
    property p_no_ack_serial; !two_wire_selected |-> !two_wire_data_oe; endproperty
    property p_open_drain; two_wire_data_oe |-> !two_wire_data_out; endproperty
    property p_tx_serial_only; $fell(host_serial_out) |-> !two_wire_selected; endproperty
    property p_start_bit; $fell(host_serial_out) |-> !host_serial_out [*8]; endproperty
    property p_oe_clock_low; $changed(two_wire_data_oe) |-> !two_wire_clock_pin; endproperty
    property p_push_settle; core_push_valid && core_push_ready |=> !core_pop_valid; endproperty
    a_strap_take: assert property (p_strap_take) else $error("strap capture");
    a_strap_hold: assert property (p_strap_hold) else $error("strap changed");
    a_no_ack_serial: assert property (p_no_ack_serial) else $error("ack in serial mode");
    a_open_drain: assert property (p_open_drain) else $error("data driven high");
    a_tx_serial_only: assert property (p_tx_serial_only) else $error("serial in two-wire");
    a_start_bit: assert property (p_start_bit) else $error("short start bit");
    a_oe_clock_low: assert property (p_oe_clock_low) else $error("data moved, clock high");
    a_push_settle: assert property (p_push_settle) else $error("head not settling");
    c_reply: cover property ($fell(host_serial_out));
    c_ack: cover property ($rose(two_wire_data_oe));
    c_pop: cover property (core_pop_valid && core_pop_ready);
endmodule : nfc_host_port_assertions
bind nfc_host_port nfc_host_port_assertions #(.QUEUE_DEPTH(QUEUE_DEPTH)) chk (
    .sys_clk, .reset_n, .interface_select_strap, .host_serial_in, .host_serial_out,
    .two_wire_clock_pin, .two_wire_data_in, .two_wire_data_out, .two_wire_data_oe,
    .two_wire_selected, .core_push_valid, .core_push_ready, .core_push_data,
    .core_pop_valid, .core_pop_ready, .core_pop_data);

/* File: nfc_host_port_tb.sv */
`timescale 1ns/1ps
module nfc_host_port_tb;
    logic        sys_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        strap = 1'b1;
    logic        ser_in, ser_out, tw_out, tw_oe, tw_sel, push_ready, pop_valid, ok, ack;
    logic        tw_clk = 1'b1;
    logic        tw_drv = 1'b1;
    // pull-up on the data wire: low when either side pulls
    wire         tw_wire = tw_drv & ~(tw_oe & ~tw_out);
    logic        push_valid = 1'b0;
    logic        pop_ready = 1'b0;
    logic  [7:0] push_data = 8'h00;
    logic  [7:0] pop_data;
    logic  [1:0] sel;
    logic [15:0] crc;
    logic [15:0] presets [4] = '{16'h0000, 16'h6363, 16'hA671, 16'hFFFF};
    int          num_errors = 0;
    int          total_checks = 0;
    int          cycles = 0;
    always #5 sys_clk = ~sys_clk;
    nfc_host_port #(.QUEUE_DEPTH(8)) dut (
        .sys_clk(sys_clk), .reset_n(reset_n), .interface_select_strap(strap),
        .host_serial_in(ser_in), .host_serial_out(ser_out), .two_wire_clock_pin(tw_clk),
        .two_wire_data_in(tw_wire), .two_wire_data_out(tw_out), .two_wire_data_oe(tw_oe),
        .core_push_valid(push_valid), .core_push_ready(push_ready), .core_push_data(push_data),
        .core_pop_valid(pop_valid), .core_pop_ready(pop_ready), .core_pop_data(pop_data),
        .two_wire_selected(tw_sel));
    serial_host_model host (.sys_clk(sys_clk), .to_device(ser_in), .from_device(ser_out));
    task automatic stop_test;
        if (num_errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : stop_test
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 100000) begin
            num_errors++;
            stop_test();
        end
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b,
                                              input logic msb);
        for (int i = 0; i < 8; i++)
            if (msb) c = (c[15] ^ b[7 - i]) ? {c[14:0], 1'b0} ^ 16'h1021 : {c[14:0], 1'b0};
            else c = (c[0] ^ b[i]) ? (c >> 1) ^ 16'h8408 : c >> 1;
        return c;
    endfunction : crc_step
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        host.send_byte({2'b00, a});
        host.send_byte(d);
    endtask : wr
    task automatic rc(input string what, input logic [7:0] ab, input logic [7:0] exp);
        logic [7:0] d;
        fork
            host.send_byte(ab);
            host.recv_byte(d, ok);
        join
        chk("reply frame", 8'h01, 8'(ok));
        chk(what, exp, d);
    endtask : rc
    task automatic tw_half;
        repeat (4) @(posedge sys_clk);
    endtask : tw_half
    task automatic tw_bit(input logic b);
        tw_drv <= b;
        tw_half();
        tw_clk <= 1'b1;
        tw_half();
        ack = ~tw_wire;
        tw_clk <= 1'b0;
        tw_half();
    endtask : tw_bit
    task automatic tw_frame(input logic [7:0] b, input logic exp);
        tw_drv <= 1'b0;
        tw_half();
        tw_clk <= 1'b0;
        tw_half();
        for (int i = 7; i >= 0; i--) tw_bit(b[i]);
        tw_bit(1'b1);
        chk("address ack", 8'(exp), 8'(ack));
        for (int i = 7; exp && i >= 0; i--) tw_bit(i < 5);
        if (exp) tw_bit(1'b1);
        if (exp) chk("register ack", 8'h01, 8'(ack));
        tw_drv <= 1'b0;
        tw_half();
        tw_clk <= 1'b1;
        tw_half();
        tw_drv <= 1'b1;
        tw_half();
    endtask : tw_frame
    task automatic wait_edge(ref logic flag);
        for (int n = 0; n < 20; n++) begin
            @(posedge sys_clk);
            if (flag === 1'b1) break;
        end
    endtask : wait_edge
    initial begin
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        tw_frame(8'h50, 1'b1);
        tw_frame(8'h52, 1'b0);
        reset_n <= 1'b0;
        strap <= 1'b0;
        repeat (20) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
        wr(6'h1F, 8'h15);
        host.period = 22;
        rc("rate", 8'hDF, 8'h15);
        rc("unmapped", 8'hBE, 8'h00);
        for (int i = 0; i < 9; i++) wr(6'h09, 8'(8'h30 + i));
        rc("level", 8'h8A, 8'h08);
        for (int i = 0; i < 8; i++) rc("queue data", 8'h89, 8'(8'h30 + i));
        rc("overrun", 8'h86, 8'h01);
        wr(6'h09, 8'h5A);
        wr(6'h0A, 8'h80);
        rc("level", 8'h8A, 8'h00);
        rc("overrun", 8'h86, 8'h00);
        wr(6'h09, 8'hC3);
        pop_ready <= 1'b1;
        wait_edge(pop_valid);
        chk("core data", 8'hC3, pop_data);
        pop_ready <= 1'b0;
        push_data <= 8'hA5;
        push_valid <= 1'b1;
        wait_edge(push_ready);
        push_valid <= 1'b0;
        rc("queue data", 8'h89, 8'hA5);
        for (int p = 0; p < 4; p++) begin
            sel = 2'(p);
            wr(6'h11, {5'b00000, sel[0], sel});
            wr(6'h11, {5'b10000, sel[0], sel});
            wr(6'h23, 8'h63);
            wr(6'h23, 8'h0E);
            crc = crc_step(crc_step(presets[sel], 8'h63, sel[0]), 8'h0E, sel[0]);
            rc("crc high", 8'hA1, crc[15:8]);
            rc("crc low", 8'hA2, crc[7:0]);
        end
        stop_test();
    end
endmodule : nfc_host_port_tb

/* File: nfc_host_regs.svh */
`ifndef NFC_HOST_REGS_SVH
`define NFC_HOST_REGS_SVH
// register addresses on the 6-bit host address space
`define ADDR_OVERRUN_STATUS  6'h06
`define ADDR_QUEUE_DATA      6'h09
`define ADDR_QUEUE_LEVEL     6'h0A
`define ADDR_CHECKSUM_CTRL   6'h11
`define ADDR_SERIAL_RATE     6'h1F
`define ADDR_CHECKSUM_HIGH   6'h21
`define ADDR_CHECKSUM_LOW    6'h22
`define ADDR_CHECKSUM_FEED   6'h23
// field positions
`define ADDR_BYTE_READ_BIT   7
`define LEVEL_FLUSH_BIT      7
`define CTRL_RESTART_BIT     7
`define CTRL_ORDER_BIT       2
// reset values and constants
`define SERIAL_RATE_RESET    8'hEB
`define RATE_MANT_OFFSET     13'h0021
`define TWO_WIRE_DEV_ADDR    7'h28
`define CHECKSUM_CTRL_RESET  8'h00
`define CHECKSUM_POLY_MSB    16'h1021
`define CHECKSUM_POLY_LSB    16'h8408
`define CHECKSUM_PRESET_0    16'h0000
`define CHECKSUM_PRESET_1    16'h6363
`define CHECKSUM_PRESET_2    16'hA671
`define CHECKSUM_PRESET_3    16'hFFFF
`endif

/* File: serial_host_model.sv */
`timescale 1ns/1ps
module serial_host_model (
    // clock
    input  wire logic sys_clk,
    // serial lines seen from the host
    output logic      to_device,
    input  wire logic from_device
);
    int period = 2816;
    initial to_device = 1'b1;
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            to_device <= frame[i];
            repeat (period) @(posedge sys_clk);
        end
    endtask : send_byte
    task automatic recv_byte(output logic [7:0] b, output logic ok);
        int n;
        n = 0;
        while (from_device === 1'b1 && n < 40 * period) begin
            @(posedge sys_clk);
            n++;
        end
        repeat (period / 2) @(posedge sys_clk);
        ok = from_device === 1'b0;
        for (int i = 0; i < 8; i++) begin
            repeat (period) @(posedge sys_clk);
            b[i] = from_device;
        end
        repeat (period) @(posedge sys_clk);
        ok = ok && from_device === 1'b1;
    endtask : recv_byte
endmodule : serial_host_model
